// [include/mac_fifo_pkg.sv]
// register map, field positions and reset values of the mac fifo controller
`default_nettype none
package mac_fifo_pkg;
  localparam int          PTR_W         = 9;
  localparam int          DEPTH         = 256;
  localparam logic [15:0] TX_PUSH_ADDR  = 16'h2000;
  localparam logic [15:0] TX_WP_ADDR    = 16'h2001;
  localparam logic [15:0] TX_RP_ADDR    = 16'h2002;
  localparam logic [15:0] TX_CTL_ADDR   = 16'h2003;
  localparam logic [15:0] TX_STS_ADDR   = 16'h2004;
  localparam logic [15:0] TX_SIZE_ADDR  = 16'h2005;
  localparam logic [15:0] TX_SBASE_ADDR = 16'h2007;
  localparam logic [15:0] TX_SLEN_ADDR  = 16'h2008;
  localparam logic [15:0] RX_POP_ADDR   = 16'h2080;
  localparam logic [15:0] RX_WP_ADDR    = 16'h2081;
  localparam logic [15:0] RX_RP_ADDR    = 16'h2082;
  localparam logic [15:0] RX_CTL_ADDR   = 16'h2083;
  localparam logic [15:0] RX_STS_ADDR   = 16'h2084;
  localparam logic [15:0] RX_SIZE_ADDR  = 16'h2085;
  localparam logic [15:0] RX_SBASE_ADDR = 16'h2087;
  localparam logic [15:0] RX_SLEN_ADDR  = 16'h2088;
  localparam logic [15:0] IRQ_STS_ADDR  = 16'h20f0;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'h20f1;
  // control register fields
  localparam int          CTL_CLR       = 0;
  localparam int          CTL_ENA       = 1;
  localparam int          CTL_AUTO      = 2;
  localparam logic [2:0]  CTL_RESET     = 3'h6;
  // status register fields
  localparam int          STS_EMPTY     = 0;
  localparam int          STS_FULL      = 1;
  localparam int          STS_RP8       = 6;
  localparam int          STS_WP8       = 7;
  // interrupt status fields
  localparam int          IRQ_TX_OVF    = 0;
  localparam int          IRQ_RX_OVF    = 1;
  localparam int          IRQ_RX_PKT    = 2;
  localparam int          IRQ_W         = 3;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
endpackage : mac_fifo_pkg
`default_nettype wire

// [logic/mac_fifo_ctrl.sv]
// transmit and receive circular byte fifo control for the wireless mac
//
// Chosen here: strobed register access.
`default_nettype none
module mac_fifo_ctrl (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        tx_pop_i,
  input  wire logic        tx_pkt_start_i,
  output logic      [7:0]  tx_data_o,
  input  wire logic        rx_push_i,
  input  wire logic [7:0]  rx_push_data_i,
  input  wire logic        rx_pkt_start_i,
  output logic             irq_o
);

  function automatic logic is_full(input logic [8:0] wp, input logic [8:0] rp);
    is_full = (wp[7:0] == rp[7:0]) && (wp[8] != rp[8]);
  endfunction : is_full

  function automatic logic is_empty(input logic [8:0] wp, input logic [8:0] rp);
    is_empty = (wp == rp);
  endfunction : is_empty

  logic [7:0]  tx_mem [mac_fifo_pkg::DEPTH];
  logic [7:0]  rx_mem [mac_fifo_pkg::DEPTH];

  logic [8:0]  tx_wp_r;
  logic [8:0]  tx_rp_r;
  logic [8:0]  rx_wp_r;
  logic [8:0]  rx_rp_r;
  logic [8:0]  tx_wp_nxt;
  logic [8:0]  tx_rp_nxt;
  logic [8:0]  rx_wp_nxt;
  logic [8:0]  rx_rp_nxt;
  logic [2:0]  tx_ctl_r;
  logic [2:0]  rx_ctl_r;
  logic [7:0]  tx_sbase_r;
  logic [7:0]  tx_slen_r;
  logic [7:0]  rx_sbase_r;
  logic [7:0]  rx_slen_r;
  logic [2:0]  irq_sts_r;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_sts_nxt;
  logic [7:0]  rdata_nxt;

  // register decode
  wire wr_tx_push  = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_PUSH_ADDR);
  wire wr_tx_wp    = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_WP_ADDR);
  wire wr_tx_rp    = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_RP_ADDR);
  wire wr_tx_ctl   = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_CTL_ADDR);
  wire wr_tx_sts   = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_STS_ADDR);
  wire wr_tx_sbase = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_SBASE_ADDR);
  wire wr_tx_slen  = reg_wr_i && (reg_addr_i == mac_fifo_pkg::TX_SLEN_ADDR);
  wire wr_rx_wp    = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_WP_ADDR);
  wire wr_rx_rp    = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_RP_ADDR);
  wire wr_rx_ctl   = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_CTL_ADDR);
  wire wr_rx_sts   = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_STS_ADDR);
  wire wr_rx_sbase = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_SBASE_ADDR);
  wire wr_rx_slen  = reg_wr_i && (reg_addr_i == mac_fifo_pkg::RX_SLEN_ADDR);
  wire wr_irq_sts  = reg_wr_i && (reg_addr_i == mac_fifo_pkg::IRQ_STS_ADDR);
  wire wr_irq_mask = reg_wr_i && (reg_addr_i == mac_fifo_pkg::IRQ_MASK_ADDR);
  wire rd_rx_pop   = reg_rd_i && (reg_addr_i == mac_fifo_pkg::RX_POP_ADDR);

  // fifo state
  wire       tx_ena   = tx_ctl_r[mac_fifo_pkg::CTL_ENA];
  wire       rx_ena   = rx_ctl_r[mac_fifo_pkg::CTL_ENA];
  wire       tx_auto  = tx_ctl_r[mac_fifo_pkg::CTL_AUTO];
  wire       rx_auto  = rx_ctl_r[mac_fifo_pkg::CTL_AUTO];
  wire       tx_clr   = wr_tx_ctl && reg_wdata_i[mac_fifo_pkg::CTL_CLR];
  wire       rx_clr   = wr_rx_ctl && reg_wdata_i[mac_fifo_pkg::CTL_CLR];
  wire       tx_full  = is_full(tx_wp_r, tx_rp_r);
  wire       tx_empty = is_empty(tx_wp_r, tx_rp_r);
  wire       rx_full  = is_full(rx_wp_r, rx_rp_r);
  wire       rx_empty = is_empty(rx_wp_r, rx_rp_r);
  wire [7:0] tx_size  = tx_wp_r[7:0] - tx_rp_r[7:0];
  wire [7:0] rx_size  = rx_wp_r[7:0] - rx_rp_r[7:0];
  wire [7:0] tx_sts   = {tx_wp_r[8], tx_rp_r[8], 4'h0, tx_full, tx_empty};
  wire [7:0] rx_sts   = {rx_wp_r[8], rx_rp_r[8], 4'h0, rx_full, rx_empty};

  // accepted data movements; overflow pushes are dropped and flagged
  wire tx_push_ok = wr_tx_push && tx_ena && !tx_full && !tx_clr;
  wire tx_pop_ok  = tx_pop_i && tx_ena && !tx_empty && !tx_clr;
  wire rx_push_ok = rx_push_i && rx_ena && !rx_full && !rx_clr;
  wire rx_pop_ok  = rd_rx_pop && rx_ena && !rx_empty && !rx_clr;
  wire tx_ovf     = wr_tx_push && tx_ena && tx_full;
  wire rx_ovf     = rx_push_i && rx_ena && rx_full;
  wire rx_pkt     = rx_pkt_start_i && rx_push_ok;

  // pointer next values: clear, then software write, then hardware advance
  always_comb begin
    tx_wp_nxt = tx_wp_r;
    if (tx_clr) begin
      tx_wp_nxt = '0;
    end else if (wr_tx_wp) begin
      tx_wp_nxt = {tx_wp_r[8], reg_wdata_i};
    end else if (wr_tx_sts) begin
      tx_wp_nxt = {reg_wdata_i[mac_fifo_pkg::STS_WP8], tx_wp_r[7:0]};
    end else if (tx_push_ok) begin
      tx_wp_nxt = tx_wp_r + 9'h001;
    end
  end

  always_comb begin
    tx_rp_nxt = tx_rp_r;
    if (tx_clr) begin
      tx_rp_nxt = '0;
    end else if (wr_tx_rp) begin
      tx_rp_nxt = {tx_rp_r[8], reg_wdata_i};
    end else if (wr_tx_sts) begin
      tx_rp_nxt = {reg_wdata_i[mac_fifo_pkg::STS_RP8], tx_rp_r[7:0]};
    end else if (tx_pop_ok) begin
      tx_rp_nxt = tx_rp_r + 9'h001;
    end
  end

  always_comb begin
    rx_wp_nxt = rx_wp_r;
    if (rx_clr) begin
      rx_wp_nxt = '0;
    end else if (wr_rx_wp) begin
      rx_wp_nxt = {rx_wp_r[8], reg_wdata_i};
    end else if (wr_rx_sts) begin
      rx_wp_nxt = {reg_wdata_i[mac_fifo_pkg::STS_WP8], rx_wp_r[7:0]};
    end else if (rx_push_ok) begin
      rx_wp_nxt = rx_wp_r + 9'h001;
    end
  end

  always_comb begin
    rx_rp_nxt = rx_rp_r;
    if (rx_clr) begin
      rx_rp_nxt = '0;
    end else if (wr_rx_rp) begin
      rx_rp_nxt = {rx_rp_r[8], reg_wdata_i};
    end else if (wr_rx_sts) begin
      rx_rp_nxt = {reg_wdata_i[mac_fifo_pkg::STS_RP8], rx_rp_r[7:0]};
    end else if (rx_pop_ok) begin
      rx_rp_nxt = rx_rp_r + 9'h001;
    end
  end

  // interrupt status: a new event wins over a write-one clear
  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (wr_irq_sts) begin
      irq_sts_nxt = irq_sts_r & ~reg_wdata_i[mac_fifo_pkg::IRQ_W-1:0];
    end
    irq_sts_nxt[mac_fifo_pkg::IRQ_TX_OVF] = irq_sts_nxt[mac_fifo_pkg::IRQ_TX_OVF] | tx_ovf;
    irq_sts_nxt[mac_fifo_pkg::IRQ_RX_OVF] = irq_sts_nxt[mac_fifo_pkg::IRQ_RX_OVF] | rx_ovf;
    irq_sts_nxt[mac_fifo_pkg::IRQ_RX_PKT] = irq_sts_nxt[mac_fifo_pkg::IRQ_RX_PKT] | rx_pkt;
  end

  // read mux; unmapped addresses and write-only push read zero
  always_comb begin
    case (reg_addr_i)
      mac_fifo_pkg::TX_WP_ADDR:    rdata_nxt = tx_wp_r[7:0];
      mac_fifo_pkg::TX_RP_ADDR:    rdata_nxt = tx_rp_r[7:0];
      mac_fifo_pkg::TX_CTL_ADDR:   rdata_nxt = {5'h00, tx_ctl_r};
      mac_fifo_pkg::TX_STS_ADDR:   rdata_nxt = tx_sts;
      mac_fifo_pkg::TX_SIZE_ADDR:  rdata_nxt = tx_size;
      mac_fifo_pkg::TX_SBASE_ADDR: rdata_nxt = tx_sbase_r;
      mac_fifo_pkg::TX_SLEN_ADDR:  rdata_nxt = tx_slen_r;
      mac_fifo_pkg::RX_POP_ADDR: rdata_nxt = rx_pop_ok ? rx_mem[rx_rp_r[7:0]] : 8'h00;
      mac_fifo_pkg::RX_WP_ADDR:    rdata_nxt = rx_wp_r[7:0];
      mac_fifo_pkg::RX_RP_ADDR:    rdata_nxt = rx_rp_r[7:0];
      mac_fifo_pkg::RX_CTL_ADDR:   rdata_nxt = {5'h00, rx_ctl_r};
      mac_fifo_pkg::RX_STS_ADDR:   rdata_nxt = rx_sts;
      mac_fifo_pkg::RX_SIZE_ADDR:  rdata_nxt = rx_size;
      mac_fifo_pkg::RX_SBASE_ADDR: rdata_nxt = rx_sbase_r;
      mac_fifo_pkg::RX_SLEN_ADDR:  rdata_nxt = rx_slen_r;
      mac_fifo_pkg::IRQ_STS_ADDR:  rdata_nxt = {5'h00, irq_sts_r};
      mac_fifo_pkg::IRQ_MASK_ADDR: rdata_nxt = {5'h00, irq_mask_r};
      default:                     rdata_nxt = 8'h00;
    endcase
  end

  // storage has no reset
  always_ff @(posedge clk_sys_i) begin
    if (tx_push_ok) begin
      tx_mem[tx_wp_r[7:0]] <= reg_wdata_i;
    end
    if (rx_push_ok) begin
      rx_mem[rx_wp_r[7:0]] <= rx_push_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
    end
  end

  // clear bit is a command and never stays stored
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ctl_r <= mac_fifo_pkg::CTL_RESET;
      rx_ctl_r <= mac_fifo_pkg::CTL_RESET;
    end else begin
      if (wr_tx_ctl) begin
        tx_ctl_r <= {reg_wdata_i[mac_fifo_pkg::CTL_AUTO], reg_wdata_i[mac_fifo_pkg::CTL_ENA], 1'b0};
      end
      if (wr_rx_ctl) begin
        rx_ctl_r <= {reg_wdata_i[mac_fifo_pkg::CTL_AUTO], reg_wdata_i[mac_fifo_pkg::CTL_ENA], 1'b0};
      end
    end
  end

  // security region: tx packet starts at read pointer, its first byte is the length
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_sbase_r <= mac_fifo_pkg::BYTE_RESET;
      tx_slen_r  <= mac_fifo_pkg::BYTE_RESET;
      rx_sbase_r <= mac_fifo_pkg::BYTE_RESET;
      rx_slen_r  <= mac_fifo_pkg::BYTE_RESET;
    end else begin
      if (tx_pkt_start_i && tx_auto) begin
        tx_sbase_r <= tx_rp_r[7:0];
        tx_slen_r  <= tx_mem[tx_rp_r[7:0]];
      end else begin
        if (wr_tx_sbase) begin
          tx_sbase_r <= reg_wdata_i;
        end
        if (wr_tx_slen) begin
          tx_slen_r <= reg_wdata_i;
        end
      end
      if (rx_pkt && rx_auto) begin
        rx_sbase_r <= rx_wp_r[7:0];
        rx_slen_r  <= rx_push_data_i;
      end else begin
        if (wr_rx_sbase) begin
          rx_sbase_r <= reg_wdata_i;
        end
        if (wr_rx_slen) begin
          rx_slen_r <= reg_wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_sts_r   <= '0;
      irq_mask_r  <= '0;
      irq_o       <= 1'b0;
      reg_rdata_o <= 8'h00;
      tx_data_o   <= 8'h00;
    end else begin
      irq_sts_r   <= irq_sts_nxt;
      irq_mask_r  <= wr_irq_mask ? reg_wdata_i[mac_fifo_pkg::IRQ_W-1:0] : irq_mask_r;
      irq_o       <= |(irq_sts_nxt & (wr_irq_mask ? reg_wdata_i[2:0] : irq_mask_r));
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
      if (tx_pop_ok) begin
        tx_data_o <= tx_mem[tx_rp_r[7:0]];
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_tx_push_adv: assert property (tx_push_ok && !wr_tx_sts
      |=> tx_wp_r == $past(tx_wp_r) + 9'h001)
    else $error("tx write pointer did not advance on push");
  a_tx_pop_adv: assert property (tx_pop_ok && !wr_tx_rp && !wr_tx_sts
      |=> tx_rp_r == $past(tx_rp_r) + 9'h001 && tx_data_o == $past(tx_mem[tx_rp_r[7:0]]))
    else $error("tx pop did not advance or deliver byte");
  a_tx_auto_load: assert property (tx_pkt_start_i && tx_auto
      |=> tx_sbase_r == $past(tx_rp_r[7:0]) && tx_slen_r == $past(tx_mem[tx_rp_r[7:0]]))
    else $error("tx encrypt region not auto loaded");
  a_tx_dis_hold: assert property (!tx_ena && !tx_clr && !wr_tx_wp && !wr_tx_sts
      |=> $stable(tx_wp_r))
    else $error("disabled tx fifo accepted a push");
  a_tx_clr_init: assert property (tx_clr
      |=> tx_wp_r == 9'h000 && tx_rp_r == 9'h000 ##1 !tx_ctl_r[0])
    else $error("tx clear did not reinitialise pointers");
  a_tx_msb_write: assert property (wr_tx_sts
      |=> tx_wp_r[8] == $past(reg_wdata_i[mac_fifo_pkg::STS_WP8])
        && tx_rp_r[8] == $past(reg_wdata_i[mac_fifo_pkg::STS_RP8]))
    else $error("tx status write did not set pointer msbs");
  a_tx_sts_read: assert property (reg_rd_i && reg_addr_i == mac_fifo_pkg::TX_STS_ADDR
      |=> reg_rdata_o == $past(tx_sts))
    else $error("tx status read wrong");
  a_tx_full_stop: assert property (tx_full && tx_ena && wr_tx_push && !wr_tx_wp
      && !tx_clr && !wr_tx_sts |=> $stable(tx_wp_r) && irq_sts_r[mac_fifo_pkg::IRQ_TX_OVF])
    else $error("push into full tx fifo not refused");
  a_tx_empty_pop: assert property (tx_empty && tx_pop_i && !tx_clr
      && !wr_tx_rp && !wr_tx_sts |=> $stable(tx_rp_r))
    else $error("pop from empty tx fifo moved pointer");
  a_tx_size_rd: assert property (reg_rd_i && reg_addr_i == mac_fifo_pkg::TX_SIZE_ADDR
      |=> reg_rdata_o == $past(tx_wp_r[7:0]) - $past(tx_rp_r[7:0]))
    else $error("tx size read wrong");
  a_rx_pop_data: assert property (rx_pop_ok && !wr_rx_rp
      |=> reg_rdata_o == $past(rx_mem[rx_rp_r[7:0]]) && rx_rp_r == $past(rx_rp_r) + 9'h001)
    else $error("rx pop returned wrong byte");
  a_rx_push_adv: assert property (rx_push_ok && !wr_rx_wp && !wr_rx_sts
      |=> rx_wp_r == $past(rx_wp_r) + 9'h001)
    else $error("rx write pointer did not advance");
  a_rx_empty_pop: assert property (rx_empty && rd_rx_pop && !wr_rx_rp
      |=> $stable(rx_rp_r))
    else $error("pop from empty rx fifo moved pointer");
  a_rx_auto_load: assert property (rx_pkt && rx_auto
      |=> rx_sbase_r == $past(rx_wp_r[7:0]) && rx_slen_r == $past(rx_push_data_i))
    else $error("rx decrypt region not auto loaded");
  a_rx_dis_hold: assert property (!rx_ena && !rx_clr && !wr_rx_wp && !wr_rx_sts
      |=> $stable(rx_wp_r))
    else $error("disabled rx fifo accepted a push");
  a_rx_clr_init: assert property (rx_clr |=> rx_wp_r == 9'h000 && rx_rp_r == 9'h000)
    else $error("rx clear did not reinitialise pointers");
  a_rx_sts_read: assert property (reg_rd_i && reg_addr_i == mac_fifo_pkg::RX_STS_ADDR
      |=> reg_rdata_o == $past(rx_sts))
    else $error("rx status read wrong");
  a_rx_full_stop: assert property (rx_full && rx_ena && rx_push_i && !rx_clr
      && !wr_rx_wp && !wr_rx_sts |=> $stable(rx_wp_r) && irq_sts_r[mac_fifo_pkg::IRQ_RX_OVF])
    else $error("push into full rx fifo not refused");
  a_irq_level: assert property (irq_o == |(irq_sts_r & irq_mask_r))
    else $error("interrupt output disagrees with masked status");

endmodule : mac_fifo_ctrl
`default_nettype wire

// [verif/phy_model.sv]
// far-side model: radio datapath that takes tx bytes and delivers rx bytes
`default_nettype none
module phy_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] tx_data_i,
  output var  logic       tx_pop_o,
  output var  logic       tx_pkt_start_o,
  output var  logic       rx_push_o,
  output var  logic [7:0] rx_push_data_o,
  output var  logic       rx_pkt_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_pop_o       = 1'b0;
    tx_pkt_start_o = 1'b0;
    rx_push_o      = 1'b0;
    rx_push_data_o = 8'h00;
    rx_pkt_start_o = 1'b0;
  end
  // one byte taken per pulse, its value is read in the following cycle
  task automatic pop_tx(output logic [7:0] data);
    @(posedge clk_sys_i);
    tx_pop_o <= 1'b1;
    @(posedge clk_sys_i);
    tx_pop_o <= 1'b0;
    #1;
    data = tx_data_i;
  endtask : pop_tx
  task automatic start_tx();
    @(posedge clk_sys_i);
    tx_pkt_start_o <= 1'b1;
    @(posedge clk_sys_i);
    tx_pkt_start_o <= 1'b0;
  endtask : start_tx
  task automatic push_rx(input logic [7:0] data, input logic first);
    @(posedge clk_sys_i);
    rx_push_o      <= 1'b1;
    rx_push_data_o <= data;
    rx_pkt_start_o <= first;
    @(posedge clk_sys_i);
    rx_push_o      <= 1'b0;
    rx_pkt_start_o <= 1'b0;
    // released data line shows a changed value, not the stale byte
    rx_push_data_o <= ~data;
  endtask : push_rx
endmodule : phy_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking testbench for the mac fifo controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i;
  logic        rstn_i;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        tx_pop;
  logic        tx_pkt_start;
  logic [7:0]  tx_data;
  logic        rx_push;
  logic [7:0]  rx_push_data;
  logic        rx_pkt_start;
  logic        irq;
  int          num_errors;
  int          checked;
  logic [7:0]  d;

  mac_fifo_ctrl uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .tx_pop_i(tx_pop), .tx_pkt_start_i(tx_pkt_start), .tx_data_o(tx_data),
    .rx_push_i(rx_push), .rx_push_data_i(rx_push_data), .rx_pkt_start_i(rx_pkt_start),
    .irq_o(irq));
  phy_model phy (.clk_sys_i(clk_sys_i), .tx_data_i(tx_data), .tx_pop_o(tx_pop),
    .tx_pkt_start_o(tx_pkt_start), .rx_push_o(rx_push), .rx_push_data_o(rx_push_data),
    .rx_pkt_start_o(rx_pkt_start));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr    <= 1'b0;
  endtask : wr

  // read strobe for one cycle, data judged in the cycle after it
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  task automatic t_reset();
    rd(mac_fifo_pkg::TX_CTL_ADDR, 8'h06);
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h01);
    rd(mac_fifo_pkg::TX_SIZE_ADDR, 8'h00);
    rd(mac_fifo_pkg::TX_RP_ADDR, 8'h00);
    rd(mac_fifo_pkg::RX_CTL_ADDR, 8'h06);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h01);
    rd(16'h2006, 8'h00);
  endtask : t_reset

  task automatic t_tx_flow();
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'ha1);
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'hb2);
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'hc3);
    rd(mac_fifo_pkg::TX_WP_ADDR, 8'h03);
    rd(mac_fifo_pkg::TX_SIZE_ADDR, 8'h03);
    phy.pop_tx(d);
    chk(d, 8'ha1);
    phy.pop_tx(d);
    chk(d, 8'hb2);
    rd(mac_fifo_pkg::TX_RP_ADDR, 8'h02);
    rd(mac_fifo_pkg::TX_SIZE_ADDR, 8'h01);
    phy.pop_tx(d);
    chk(d, 8'hc3);
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h01);
    phy.pop_tx(d);
    chk(d, 8'hc3);
    rd(mac_fifo_pkg::TX_RP_ADDR, 8'h03);
  endtask : t_tx_flow

  task automatic t_tx_full();
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h07);
    rd(mac_fifo_pkg::TX_WP_ADDR, 8'h00);
    for (int i = 0; i < mac_fifo_pkg::DEPTH; i++) begin
      wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'(i));
    end
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h82);
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'hee);
    rd(mac_fifo_pkg::TX_WP_ADDR, 8'h00);
    rd(mac_fifo_pkg::IRQ_STS_ADDR, 8'h01);
    wr(mac_fifo_pkg::IRQ_MASK_ADDR, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(mac_fifo_pkg::IRQ_STS_ADDR, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({7'h00, irq}, 8'h00);
    phy.pop_tx(d);
    chk(d, 8'h00);
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h80);
    wr(mac_fifo_pkg::TX_STS_ADDR, 8'h40);
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h40);
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h07);
    rd(mac_fifo_pkg::TX_STS_ADDR, 8'h01);
    rd(mac_fifo_pkg::TX_RP_ADDR, 8'h00);
  endtask : t_tx_full

  task automatic t_tx_auto();
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'h05);
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'h77);
    phy.start_tx();
    rd(mac_fifo_pkg::TX_SBASE_ADDR, 8'h00);
    rd(mac_fifo_pkg::TX_SLEN_ADDR, 8'h05);
    wr(mac_fifo_pkg::TX_SBASE_ADDR, 8'h3c);
    rd(mac_fifo_pkg::TX_SBASE_ADDR, 8'h3c);
    wr(mac_fifo_pkg::TX_SLEN_ADDR, 8'h12);
    rd(mac_fifo_pkg::TX_SLEN_ADDR, 8'h12);
    phy.pop_tx(d);
    chk(d, 8'h05);
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h02);
    phy.start_tx();
    rd(mac_fifo_pkg::TX_SBASE_ADDR, 8'h3c);
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h06);
    phy.start_tx();
    rd(mac_fifo_pkg::TX_SBASE_ADDR, 8'h01);
    rd(mac_fifo_pkg::TX_SLEN_ADDR, 8'h77);
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h04);
    wr(mac_fifo_pkg::TX_PUSH_ADDR, 8'h99);
    rd(mac_fifo_pkg::TX_WP_ADDR, 8'h02);
    phy.pop_tx(d);
    rd(mac_fifo_pkg::TX_RP_ADDR, 8'h01);
    wr(mac_fifo_pkg::TX_CTL_ADDR, 8'h06);
  endtask : t_tx_auto

  task automatic t_rx();
    logic [7:0] pkt [4];
    pkt = '{8'h03, 8'h11, 8'h22, 8'h33};
    foreach (pkt[i]) begin
      phy.push_rx(pkt[i], i == 0);
    end
    rd(mac_fifo_pkg::RX_WP_ADDR, 8'h04);
    rd(mac_fifo_pkg::RX_SIZE_ADDR, 8'h04);
    rd(mac_fifo_pkg::RX_SBASE_ADDR, 8'h00);
    rd(mac_fifo_pkg::RX_SLEN_ADDR, 8'h03);
    rd(mac_fifo_pkg::IRQ_STS_ADDR, 8'h04);
    chk({7'h00, irq}, 8'h00);
    foreach (pkt[i]) begin
      rd(mac_fifo_pkg::RX_POP_ADDR, pkt[i]);
    end
    rd(mac_fifo_pkg::RX_RP_ADDR, 8'h04);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h01);
    rd(mac_fifo_pkg::RX_POP_ADDR, 8'h00);
    rd(mac_fifo_pkg::RX_RP_ADDR, 8'h04);
    wr(mac_fifo_pkg::RX_CTL_ADDR, 8'h04);
    phy.push_rx(8'h55, 1'b0);
    rd(mac_fifo_pkg::RX_WP_ADDR, 8'h04);
    wr(mac_fifo_pkg::RX_CTL_ADDR, 8'h06);
    phy.push_rx(8'h66, 1'b0);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h00);
    wr(mac_fifo_pkg::RX_CTL_ADDR, 8'h07);
    rd(mac_fifo_pkg::RX_WP_ADDR, 8'h00);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h01);
    // auto setup off: a packet start must leave the decrypt region alone
    wr(mac_fifo_pkg::RX_CTL_ADDR, 8'h03);
    for (int i = 0; i < mac_fifo_pkg::DEPTH; i++) begin
      phy.push_rx(8'(i), i == 0);
    end
    rd(mac_fifo_pkg::RX_SLEN_ADDR, 8'h03);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h82);
    phy.push_rx(8'hee, 1'b0);
    rd(mac_fifo_pkg::RX_WP_ADDR, 8'h00);
    rd(mac_fifo_pkg::IRQ_STS_ADDR, 8'h06);
    rd(mac_fifo_pkg::RX_POP_ADDR, 8'h00);
    rd(mac_fifo_pkg::RX_POP_ADDR, 8'h01);
    rd(mac_fifo_pkg::RX_STS_ADDR, 8'h80);
    wr(mac_fifo_pkg::RX_CTL_ADDR, 8'h07);
  endtask : t_rx

  initial begin
    num_errors = 0;
    checked    = 0;
    rstn_i     = 1'b0;
    reg_addr   = 16'h0000;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_tx_flow();
    t_tx_full();
    t_tx_auto();
    t_rx();
    close_out();
  end

  // watchdog: the whole sequence needs about 1230 cycles
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    num_errors++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
